// ===== core/ums_params.svh
`ifndef UMS_PARAMS_SVH
`define UMS_PARAMS_SVH
// register offsets
`define UMS_ADDR_MODEM_CTRL 3'h4
`define UMS_ADDR_MODEM_STAT 3'h6
`define UMS_ADDR_IER 3'h1
`define UMS_ADDR_EFR 3'h2
// modem control bit positions
`define UMS_MCTL_DTR 0
`define UMS_MCTL_RTS 1
`define UMS_MCTL_USER_ONE 2
`define UMS_MCTL_USER_TWO 3
`define UMS_MCTL_LOOP 4
`define UMS_MCTL_RESET 8'h00
// modem status bit positions
`define UMS_MSTAT_CTS_CHG 0
`define UMS_MSTAT_DSR_CHG 1
`define UMS_MSTAT_RI_CHG 2
`define UMS_MSTAT_DCD_CHG 3
`define UMS_MSTAT_CTS 4
`define UMS_MSTAT_DSR 5
`define UMS_MSTAT_RI 6
`define UMS_MSTAT_DCD 7
// interrupt enable and flow control bit positions
`define UMS_IER_RXDATA 0
`define UMS_IER_THRE 1
`define UMS_IER_RXERR 2
`define UMS_IER_MODEM 3
`define UMS_IER_RESET 8'h00
`define UMS_CFG_AUTOCTS 0
`define UMS_CFG_FIFOEN 1
`define UMS_CFG_RESET 8'h00
`endif

// ===== core/ums_pkg.sv
package ums_pkg;
   // modem-side inputs travel together
   typedef struct packed {
      logic cts;
      logic dsr;
      logic ri;
      logic dcd;
   } ums_modem_s;
   // whole state of the block
   typedef struct packed {
      logic [7:0] mctl;
      logic [7:0] ier;
      logic [7:0] cfg;
      logic [3:0] delta;
      ums_modem_s prev;
      logic [7:0] rdata;
      logic rdValid;
   } ums_state_s;
endpackage : ums_pkg

// ===== core/ums_modem_signal_logic.sv
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ums_params.svh"
// Functional notes
// (R1) status bit 4 shows clear-to-send level
// (R2) clear-to-send change flagged since last read
// (R3) cts change interrupts only without auto-cts
// (R4) auto-cts gates transmitter send permission
// (R5) status bit 7 shows carrier-detect level
// (R6) status bit 3 flags carrier change
// (R7) carrier change interrupts when modem enabled
// (R8) driver disable low during host reads
// (R9) status bit 5 shows data-set-ready level
// (R10) status bit 1 flags dsr change
// (R11) dsr change interrupts when modem enabled
// (R12) dtr output low when control bit set
// (R13) dtr high at reset, loopback, cleared
// (R14) interrupt high for any enabled pending source
// (R15) receive timeout counts only with fifos
// (R16) interrupt drops when serviced or reset
// (R17) user outputs low when control bits set
// (R18) user outputs high reset, loopback, cleared
// (R19) eight-bit bus driven only on reads
// (R20) reset clears registers, outputs to defaults
// (R21) status read clears flags, coincident change kept
// (R22) loopback routes control bits to status inputs
module ums_modem_signal_logic
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [7:0] rdData,
   output logic [7:0] dataOut,
   output logic dataOutEn_n,
   input wire ums_pkg::ums_modem_s modemIn,
   input wire logic rxErr,
   input wire logic rxAvail,
   input wire logic rxTimeout,
   input wire logic thrEmpty,
   output logic txAllowed,
   output logic driverDisableOut_n,
   output logic dtrOut_n,
   output logic rtsOut_n,
   output logic userOutputOne_n,
   output logic userOutputTwo_n,
   output logic intOut
);
   ums_pkg::ums_state_s state_q;
   ums_pkg::ums_state_s state_d;
   ums_pkg::ums_modem_s eff;
   logic loopback;
   logic [7:0] status;
   logic modemInt;
   logic autoCts;

   // ************************************************************
   // effective modem inputs
   // ************************************************************
   assign loopback = state_q.mctl[`UMS_MCTL_LOOP];
   assign autoCts = state_q.cfg[`UMS_CFG_AUTOCTS];
   always_comb
   begin
      if (loopback)
      begin
         // control bits fed back as status inputs
         eff.cts = state_q.mctl[`UMS_MCTL_RTS]; // R22
         eff.dsr = state_q.mctl[`UMS_MCTL_DTR]; // R22
         eff.ri = state_q.mctl[`UMS_MCTL_USER_ONE]; // R22
         eff.dcd = state_q.mctl[`UMS_MCTL_USER_TWO]; // R22
      end
      else
      begin
         // pins are active low, status reports asserted as one
         eff.cts = ~modemIn.cts;
         eff.dsr = ~modemIn.dsr;
         eff.ri = ~modemIn.ri;
         eff.dcd = ~modemIn.dcd;
      end
   end

   // ************************************************************
   // modem status byte
   // ************************************************************
   always_comb
   begin
      status = 8'h00;
      status[`UMS_MSTAT_CTS] = eff.cts; // R1
      status[`UMS_MSTAT_DSR] = eff.dsr; // R9
      status[`UMS_MSTAT_RI] = eff.ri;
      status[`UMS_MSTAT_DCD] = eff.dcd; // R5
      status[`UMS_MSTAT_CTS_CHG] = state_q.delta[0]; // R2
      status[`UMS_MSTAT_DSR_CHG] = state_q.delta[1]; // R10
      status[`UMS_MSTAT_RI_CHG] = state_q.delta[2];
      status[`UMS_MSTAT_DCD_CHG] = state_q.delta[3]; // R6
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic [3:0] change;
      logic [3:0] clr;
      change = {eff.dcd ^ state_q.prev.dcd, eff.ri & ~state_q.prev.ri,
                eff.dsr ^ state_q.prev.dsr, eff.cts ^ state_q.prev.cts};
      clr = (rdStb && addr == `UMS_ADDR_MODEM_STAT) ? 4'hf : 4'h0;
      state_d = state_q;
      // set wins over the read clear
      state_d.delta = (state_q.delta & ~clr) | change; // R21 R2 R6 R10
      state_d.prev = eff;
      if (wrStb)
      begin
         unique case (addr)
            `UMS_ADDR_MODEM_CTRL: state_d.mctl = {3'h0, wrData[4:0]};
            `UMS_ADDR_IER: state_d.ier = {4'h0, wrData[3:0]};
            `UMS_ADDR_EFR: state_d.cfg = {6'h0, wrData[1:0]};
            default: ;
         endcase
      end
      // read data held for the following cycle only
      state_d.rdValid = rdStb;
      state_d.rdata = 8'h00;
      if (rdStb)
      begin
         unique case (addr)
            `UMS_ADDR_MODEM_CTRL: state_d.rdata = state_q.mctl;
            `UMS_ADDR_IER: state_d.rdata = state_q.ier;
            `UMS_ADDR_EFR: state_d.rdata = state_q.cfg;
            `UMS_ADDR_MODEM_STAT: state_d.rdata = status;
            default: state_d.rdata = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q.mctl <= `UMS_MCTL_RESET; // R20
         state_q.ier <= `UMS_IER_RESET; // R20
         state_q.cfg <= `UMS_CFG_RESET;
         state_q.delta <= 4'h0;
         state_q.prev <= '0;
         state_q.rdata <= 8'h00;
         state_q.rdValid <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ************************************************************
   // interrupt and flow control
   // ************************************************************
   always_comb
   begin
      // cts change is ignored while auto-cts owns that pin
      modemInt = state_q.ier[`UMS_IER_MODEM] &
                 ((state_q.delta[0] & ~autoCts) | // R3
                  state_q.delta[1] | // R11
                  state_q.delta[2] |
                  state_q.delta[3]); // R7
      // pending sources clear when serviced by the caller
      intOut = modemInt | // R14 R16
               (state_q.ier[`UMS_IER_RXERR] & rxErr) |
               (state_q.ier[`UMS_IER_RXDATA] & rxAvail) |
               (state_q.ier[`UMS_IER_RXDATA] & rxTimeout &
                state_q.cfg[`UMS_CFG_FIFOEN]) | // R15
               (state_q.ier[`UMS_IER_THRE] & thrEmpty);
      txAllowed = autoCts ? eff.cts : 1'b1; // R4
   end

   // ************************************************************
   // pins
   // ************************************************************
   assign dtrOut_n = ~(state_q.mctl[`UMS_MCTL_DTR] & ~loopback); // R12 R13
   assign rtsOut_n = ~(state_q.mctl[`UMS_MCTL_RTS] & ~loopback);
   assign userOutputOne_n = ~(state_q.mctl[`UMS_MCTL_USER_ONE] & ~loopback); // R17 R18
   assign userOutputTwo_n = ~(state_q.mctl[`UMS_MCTL_USER_TWO] & ~loopback); // R17 R18
   assign driverDisableOut_n = ~state_q.rdValid; // R8
   assign dataOutEn_n = ~state_q.rdValid; // R19
   assign dataOut = state_q.rdata; // R19
   assign rdData = state_q.rdata;
endmodule : ums_modem_signal_logic

// ===== tb/ums_modem_model.sv
`timescale 1ns/1ps
// modem side: pins take the requested levels one clock later and hold them
module ums_modem_model
(
   input wire logic clock,
   input wire logic [3:0] want,
   output ums_pkg::ums_modem_s modemIn
);
   // levels change just after an edge only
   always_ff @(posedge clock)
   begin
      modemIn <= want;
   end
endmodule : ums_modem_model

// ===== tb/ums_modem_signal_logic_asserts.sv
`timescale 1ns/1ps
module ums_modem_signal_logic_asserts
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] rdData,
   input wire logic dataOutEn_n,
   input wire ums_pkg::ums_modem_s modemIn,
   input wire logic rxErr,
   input wire logic txAllowed,
   input wire logic driverDisableOut_n,
   input wire logic dtrOut_n,
   input wire logic intOut
);
   logic loopQ;
   logic autoQ;
   logic errEnQ;
   // shadow of the loopback, auto-cts and error-enable bits
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         {loopQ, autoQ, errEnQ} <= 3'h0;
      else if (wrStb && addr == 3'h4)
         loopQ <= wrData[4];
      else if (wrStb && addr == 3'h2)
         autoQ <= wrData[0];
      else if (wrStb && addr == 3'h1)
         errEnQ <= wrData[2];
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_RD_DRV: assert property (rdStb |=> !driverDisableOut_n && !dataOutEn_n)
      else $error("bus not driven in read cycle");
   AST_IDLE_FLOAT: assert property (!rdStb |=> dataOutEn_n && driverDisableOut_n)
      else $error("bus driven outside read cycle");
   AST_DTR_ON: assert property (wrStb && addr == 3'h4 && wrData[0] && !wrData[4]
      |=> !dtrOut_n) else $error("dtr not active");
   AST_DTR_LOOP: assert property (loopQ |-> dtrOut_n) else $error("dtr active in loop");
   AST_LEVELS: assert property (rdStb && addr == 3'h6 && !loopQ |=> rdData[7:4] ==
      ~$past({modemIn.dcd, modemIn.ri, modemIn.dsr, modemIn.cts})) else $error("bad levels");
   AST_TXGATE: assert property (!loopQ |-> txAllowed == (!autoQ || !modemIn.cts))
      else $error("bad transmit gate");
   AST_INT_SRC: assert property (errEnQ && rxErr |-> intOut) else $error("int missing");
   AST_FLAG_CLR: assert property (rdStb && addr == 3'h6 && $stable(modemIn) &&
      !$past(wrStb) ##1 $stable(modemIn) ##1 rdStb && addr == 3'h6 && $stable(modemIn)
      |=> rdData[3:0] == 4'h0) else $error("flags not cleared");
endmodule : ums_modem_signal_logic_asserts
bind ums_modem_signal_logic ums_modem_signal_logic_asserts i_ums_modem_signal_logic_asserts (.*);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wrData = 8'h00;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic rxErr = 1'b0;
   logic rxTimeout = 1'b0;
   logic rxAvail = 1'b0;
   logic thrEmpty = 1'b0;
   logic [3:0] want = 4'hf;
   logic [7:0] rdData, rdv, dataOut;
   logic dataOutEn_n, txAllowed, driverDisableOut_n, dtrOut_n, rtsOut_n;
   logic userOutputOne_n, userOutputTwo_n, intOut;
   ums_pkg::ums_modem_s modemIn;
   int badCount = 0;
   int checked = 0;
   int cyc = 0;
   always #2 clock = ~clock;
   ums_modem_model i_ums_modem_model (.clock(clock), .want(want), .modemIn(modemIn));
   ums_modem_signal_logic i_ums_modem_signal_logic (.*);
   task ck(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         badCount++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : ck
   // all single-bit outputs in one byte
   task po(input logic [7:0] e);
      @(posedge clock);
      #1;
      ck({intOut, txAllowed, dtrOut_n, rtsOut_n, userOutputOne_n, userOutputTwo_n,
         dataOutEn_n, driverDisableOut_n}, e);
   endtask : po
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clock);
      wrStb <= 1'b0;
   endtask : wr
   task rd(input logic [2:0] a);
      @(posedge clock);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clock);
      rdStb <= 1'b0;
      #1;
      rdv = rdData;
      ck({dataOut[0] ^ rdv[0], driverDisableOut_n}, 8'h00);
   endtask : rd
   task pins(input logic [3:0] v);
      @(posedge clock);
      want <= v;
      repeat (3) @(posedge clock);
   endtask : pins
   task stop_test;
      $display("bad %0d checked %0d", badCount, checked);
      if (badCount == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         badCount++;
         stop_test;
      end
   end
   // main sequence: reset, outputs, status, interrupts
   initial
   begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      po(8'h7f);
      rd(3'h6);
      wr(3'h4, 8'h0d);
      po(8'h53);
      rd(3'h4);
      ck(rdv, 8'h0d);
      wr(3'h4, 8'h1d);
      po(8'h7f);
      rd(3'h6);
      ck(rdv, 8'hee);
      wr(3'h4, 8'h00);
      po(8'h7f);
      rd(3'h6);
      pins(4'h6);
      rd(3'h6);
      ck(rdv, 8'h99);
      rd(3'h6);
      ck(rdv, 8'h90);
      pins(4'h2);
      rd(3'h6);
      ck(rdv, 8'hb2);
      wr(3'h1, 8'h08);
      pins(4'h6);
      po(8'hff);
      rd(3'h6);
      po(8'h7f);
      pins(4'h7);
      po(8'hff);
      rd(3'h6);
      wr(3'h2, 8'h01);
      pins(4'hf);
      po(8'h3f);
      wr(3'h1, 8'h04);
      rxErr <= 1'b1;
      po(8'hbf);
      rxErr <= 1'b0;
      wr(3'h1, 8'h01);
      rxTimeout <= 1'b1;
      po(8'h3f);
      wr(3'h2, 8'h02);
      po(8'hff);
      rxTimeout <= 1'b0;
      rxAvail <= 1'b1;
      po(8'hff);
      rxAvail <= 1'b0;
      wr(3'h1, 8'h02);
      thrEmpty <= 1'b1;
      po(8'hff);
      thrEmpty <= 1'b0;
      po(8'h7f);
      rd(3'h1);
      ck(rdv, 8'h02);
      stop_test;
   end
endmodule : tb_top
